/* core/prxrs_consts.vh */
// register offsets, field positions and reset values of the proximity result/status slice
`ifndef PRXRS_CONSTS_VH
`define PRXRS_CONSTS_VH
`define PRXRS_OFS_STATE 8'h13
`define PRXRS_OFS_RES_LO 8'h18
`define PRXRS_OFS_RES_HI 8'h19
`define PRXRS_OFS_TRIM 8'h1e
`define PRXRS_BIT_SAT 6
`define PRXRS_BIT_IRQ 5
`define PRXRS_BIT_VALID 1
`define PRXRS_BIT_SIGN 7
`define PRXRS_RST_STATE 8'h00
`define PRXRS_RST_TRIM 8'h00
`define PRXRS_RST_RESULT 16'h0000
`define PRXRS_RST_SHADOW 8'h00
`define PRXRS_RST_RDATA 8'h00
`define PRXRS_RST_FLAG 1'b0
`endif

/* core/prxrs_offset_apply.v */
// applies the sign-magnitude offset trim to a raw result, scaled by gain, drive and pulses
`default_nettype none
module prxrs_offset_apply #(
   parameter W = 16
) (
   input wire core_clk,
   input wire nrst,
   input wire [W-1:0] raw,
   input wire [7:0] trim,
   input wire [1:0] front_end_gain,
   input wire [1:0] emitter_drive_strength,
   input wire [7:0] emitter_pulse_count,
   output reg [W-1:0] adjusted_r
);
`include "prxrs_consts.vh"
   // step size grows with gain, stronger drive (lower code) and pulse count
   wire [3:0] gain_mul = 4'h1 << front_end_gain;
   wire [3:0] drive_mul = 4'h8 >> emitter_drive_strength;
   wire [8:0] pulses = {1'b0, emitter_pulse_count} + 9'h001;
   wire [31:0] shift_amt = {25'h0, trim[6:0]} * {28'h0, gain_mul} * {28'h0, drive_mul} * {23'h0, pulses};
   wire [31:0] raw_ext = {{(32-W){1'b0}}, raw};
   wire [31:0] max_val = {{(32-W){1'b0}}, {W{1'b1}}};
   reg [W-1:0] adjusted_nxt;
   always @* begin
      if (trim[`PRXRS_BIT_SIGN]) begin
         // saturate high rather than wrap, an offset must never flip a near target to far
         if (raw_ext + shift_amt > max_val || shift_amt > max_val)
            adjusted_nxt = {W{1'b1}};
         else
            adjusted_nxt = raw + shift_amt[W-1:0];
      end else begin
         if (shift_amt >= raw_ext)
            adjusted_nxt = {W{1'b0}};
         else
            adjusted_nxt = raw - shift_amt[W-1:0];
      end
   end
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         adjusted_r <= {W{1'b0}};
      else
         adjusted_r <= adjusted_nxt;
   end
endmodule
`default_nettype wire

/* core/prxrs_regs.v */
// proximity status, result and offset trim registers
// Notes on behaviour
// - read-only 8-bit status at 0x13, zero after reset
// - status bit 6 set when last measurement saturated the front end
// - status bit 5 high while proximity interrupt is asserted
// - status bit 1 set once a cycle completes after sensing is enabled
// - result is 16-bit unsigned, readable as two bytes
// - low result byte at 0x18, high byte at 0x19
// - low-byte read copies high byte into shadow, returned on next high read
// - high-byte read stays coherent across a conversion ending between reads
// - writable sign-magnitude trim at 0x1e, magnitude 6:0, sign 7
// - sign 0 shifts result down, sign 1 up, by the magnitude
// - trim clears to zero at power-up
// - shift size scales with gain, drive strength and pulse count
// - interrupt and bus lines are open-drain, pull low only; here only int_out_oe_r is, reg_rdata_r is a plain driven output
// - interrupt after every cycle or after persistence count out of window
`default_nettype none
module prxrs_regs #(
   parameter W = 16
) (
   input wire core_clk,
   input wire nrst,
   input wire [7:0] reg_addr,
   input wire reg_rd,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata_r,
   input wire sensing_enable,
   input wire cycle_done,
   input wire [W-1:0] raw_result,
   input wire raw_saturated,
   input wire persist_hit,
   input wire irq_clear,
   input wire [1:0] front_end_gain,
   input wire [1:0] emitter_drive_strength,
   input wire [7:0] emitter_pulse_count,
   output reg int_out_oe_r
);
`include "prxrs_consts.vh"
   // ----------------------------------------
   // offset stage
   // ----------------------------------------
   reg [7:0] trim_r;
   wire [W-1:0] adjusted;
   prxrs_offset_apply #(.W(W)) u_ofs (
      .core_clk(core_clk),
      .nrst(nrst),
      .raw(raw_result),
      .trim(trim_r),
      .front_end_gain(front_end_gain),
      .emitter_drive_strength(emitter_drive_strength),
      .emitter_pulse_count(emitter_pulse_count),
      .adjusted_r(adjusted)
   );
   // ----------------------------------------
   // cycle-end alignment
   // ----------------------------------------
   // the adjusted result lags the raw count by one clock, so the cycle-end strobe
   // and the saturation level are delayed by the same amount to stay paired with it
   reg done_d_r;
   reg sat_d_r;
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         done_d_r <= `PRXRS_RST_FLAG;
         sat_d_r <= `PRXRS_RST_FLAG;
      end else begin
         done_d_r <= cycle_done;
         sat_d_r <= raw_saturated;
      end
   end
   // ----------------------------------------
   // access decode
   // ----------------------------------------
   // strobes are single-cycle pulses qualified by the offset on the same edge
   wire rd_res_lo = reg_rd && (reg_addr == `PRXRS_OFS_RES_LO);
   wire wr_trim = reg_wr && (reg_addr == `PRXRS_OFS_TRIM);
   // ----------------------------------------
   // result register
   // ----------------------------------------
   // the result keeps its last value between conversions, so polling never sees a partial count
   reg [W-1:0] result_r;
   reg [W-1:0] result_nxt;
   always @* begin
      result_nxt = result_r;
      if (done_d_r)
         result_nxt = adjusted;
   end
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         result_r <= `PRXRS_RST_RESULT;
      else
         result_r <= result_nxt;
   end
   // ----------------------------------------
   // shadow of the upper result byte
   // ----------------------------------------
   // only a lower-byte read loads the shadow; a conversion ending before the upper
   // byte is fetched leaves it alone, so the two bytes always belong to one result
   reg [7:0] shadow_hi_r;
   reg [7:0] shadow_hi_nxt;
   always @* begin
      shadow_hi_nxt = shadow_hi_r;
      if (rd_res_lo)
         shadow_hi_nxt = result_r[W-1:W-8];
   end
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         shadow_hi_r <= `PRXRS_RST_SHADOW;
      else
         shadow_hi_r <= shadow_hi_nxt;
   end
   // ----------------------------------------
   // saturation and valid flags
   // ----------------------------------------
   reg sat_flag_r;
   reg sat_flag_nxt;
   reg valid_flag_r;
   reg valid_flag_nxt;
   // saturation follows every finished cycle, it describes the front end, not the enable
   always @* begin
      sat_flag_nxt = sat_flag_r;
      if (done_d_r)
         sat_flag_nxt = sat_d_r;
   end
   // valid drops as soon as sensing is switched off, so a stale result is never flagged
   always @* begin
      valid_flag_nxt = valid_flag_r;
      if (!sensing_enable)
         valid_flag_nxt = 1'b0;
      else if (done_d_r)
         valid_flag_nxt = 1'b1;
   end
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sat_flag_r <= `PRXRS_RST_FLAG;
         valid_flag_r <= `PRXRS_RST_FLAG;
      end else begin
         sat_flag_r <= sat_flag_nxt;
         valid_flag_r <= valid_flag_nxt;
      end
   end
   // ----------------------------------------
   // proximity interrupt
   // ----------------------------------------
   // persist_hit already folds in the every-cycle or persistence choice made upstream
   wire irq_set = done_d_r && sensing_enable && persist_hit;
   reg irq_flag_r;
   reg irq_flag_nxt;
   always @* begin
      irq_flag_nxt = irq_flag_r;
      // set wins over a simultaneous clear, a fresh event must not be lost
      if (irq_set)
         irq_flag_nxt = 1'b1;
      else if (irq_clear)
         irq_flag_nxt = 1'b0;
   end
   // the pin enable copies the next flag value so that it leaves a flip-flop directly
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq_flag_r <= `PRXRS_RST_FLAG;
         int_out_oe_r <= `PRXRS_RST_FLAG;
      end else begin
         irq_flag_r <= irq_flag_nxt;
         // the pin is only ever pulled low: enable high means drive low, never high
         int_out_oe_r <= irq_flag_nxt;
      end
   end
   // ----------------------------------------
   // offset trim register
   // ----------------------------------------
   // the trim is the only writable location here; writes to any other offset are dropped
   reg [7:0] trim_nxt;
   always @* begin
      trim_nxt = trim_r;
      if (wr_trim)
         trim_nxt = reg_wdata;
   end
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         trim_r <= `PRXRS_RST_TRIM;
      else
         trim_r <= trim_nxt;
   end
   // ----------------------------------------
   // status word
   // ----------------------------------------
   // reserved positions read as zero; the interrupt bit mirrors the pin enable
   reg [7:0] status_word;
   always @* begin
      status_word = `PRXRS_RST_STATE;
      status_word[`PRXRS_BIT_SAT] = sat_flag_r;
      status_word[`PRXRS_BIT_IRQ] = int_out_oe_r;
      status_word[`PRXRS_BIT_VALID] = valid_flag_r;
   end
   // ----------------------------------------
   // read data
   // ----------------------------------------
   // a read returns what the registers held on the edge at which the strobe is taken
   reg [7:0] rdata_nxt;
   always @* begin
      rdata_nxt = reg_rdata_r;
      if (reg_rd) begin
         case (reg_addr)
            `PRXRS_OFS_STATE: rdata_nxt = status_word;
            `PRXRS_OFS_RES_LO: rdata_nxt = result_r[7:0];
            `PRXRS_OFS_RES_HI: rdata_nxt = shadow_hi_r;
            `PRXRS_OFS_TRIM: rdata_nxt = trim_r;
            // unmapped offsets read as zero
            default: rdata_nxt = 8'h00;
         endcase
      end
   end
   // read data holds between reads so a slow host sees a steady byte
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         reg_rdata_r <= `PRXRS_RST_RDATA;
      else
         reg_rdata_r <= rdata_nxt;
   end
endmodule
`default_nettype wire

/* dv/prxrs_props.sv */
// assertions on the register slice ports
`default_nettype none
module prxrs_props (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_r,
   input wire logic cycle_done,
   input wire logic persist_hit,
   input wire logic sensing_enable,
   input wire logic irq_clear,
   input wire logic int_out_oe_r
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence s_st; reg_rd && reg_addr == 8'h13; endsequence
   sequence s_hit; cycle_done && persist_hit && sensing_enable ##1 persist_hit && sensing_enable; endsequence
   property p_rsv; s_st |=> (reg_rdata_r & 8'h9d) == 8'h00; endproperty
   property p_irqb; s_st |=> reg_rdata_r[5] == $past(int_out_oe_r); endproperty
   property p_hold; !reg_rd |=> $stable(reg_rdata_r); endproperty
   property p_gap; reg_rd && reg_addr[7:2] == 6'h05 |=> reg_rdata_r == 8'h00; endproperty
   property p_set; s_hit |-> ##[1:2] int_out_oe_r; endproperty
   property p_cause; $rose(int_out_oe_r) |-> $past(cycle_done, 2) || $past(cycle_done, 3); endproperty
   property p_clr; irq_clear && !$past(cycle_done) && !$past(cycle_done, 2) |=> !int_out_oe_r; endproperty
   property p_keep; int_out_oe_r && !irq_clear |=> int_out_oe_r; endproperty
   a_rsv: assert property (p_rsv) else $error("status spare bits set");
   a_irqb: assert property (p_irqb) else $error("status irq bit wrong");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_gap: assert property (p_gap) else $error("unmapped read not zero");
   a_set: assert property (p_set) else $error("irq not raised");
   a_cause: assert property (p_cause) else $error("irq without cycle end");
   a_clr: assert property (p_clr) else $error("irq not cleared");
   a_keep: assert property (p_keep) else $error("irq dropped");
endmodule
bind prxrs_regs prxrs_props prxrs_props_inst (
   .core_clk(core_clk),
   .nrst(nrst),
   .reg_addr(reg_addr),
   .reg_rd(reg_rd),
   .reg_rdata_r(reg_rdata_r),
   .cycle_done(cycle_done),
   .persist_hit(persist_hit),
   .sensing_enable(sensing_enable),
   .irq_clear(irq_clear),
   .int_out_oe_r(int_out_oe_r)
);
`default_nettype wire

/* dv/prxrs_fe_model.sv */
// front end stand-in: result held for two cycles per request, then scrambled
`default_nettype none
module prxrs_fe_model (
   input wire logic core_clk,
   input wire logic go,
   input wire logic [15:0] val,
   output var logic cycle_done,
   output var logic [15:0] raw_result
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge core_clk) begin
      cycle_done <= go;
      raw_result <= go ? val : cycle_done ? raw_result : ~raw_result;
   end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// random bench for the status, result and trim registers
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, nrst, reg_rd, reg_wr, sensing_enable, persist_hit, irq_clear, go, raw_saturated;
   logic cycle_done, int_out_oe_r;
   logic [7:0] reg_addr, reg_wdata, emitter_pulse_count, reg_rdata_r, t;
   logic [1:0] front_end_gain, emitter_drive_strength;
   logic [15:0] val, e, raw_result;
   int n_errors, comparisons, cyc, s;
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) if (++cyc == 3000) report_and_stop(1);
   prxrs_fe_model prxrs_fe_model_inst (
      .core_clk(core_clk),
      .go(go),
      .val(val),
      .cycle_done(cycle_done),
      .raw_result(raw_result)
   );
   prxrs_regs prxrs_regs_inst (
      .core_clk(core_clk),
      .nrst(nrst),
      .reg_addr(reg_addr),
      .reg_rd(reg_rd),
      .reg_wr(reg_wr),
      .reg_wdata(reg_wdata),
      .reg_rdata_r(reg_rdata_r),
      .sensing_enable(sensing_enable),
      .cycle_done(cycle_done),
      .raw_result(raw_result),
      .raw_saturated(raw_saturated),
      .persist_hit(persist_hit),
      .irq_clear(irq_clear),
      .front_end_gain(front_end_gain),
      .emitter_drive_strength(emitter_drive_strength),
      .emitter_pulse_count(emitter_pulse_count),
      .int_out_oe_r(int_out_oe_r)
   );
   task automatic chk(input logic [15:0] x, y);
      comparisons++;
      n_errors += int'(x !== y);
      if (x !== y) $display("BAD %0t got %h want %h", $time, x, y);
   endtask
   // op is {start conversion, clear irq, read, write}; a conversion leaves room for the result to land
   task automatic acc(input logic [3:0] op, input logic [7:0] a, w);
      @(posedge core_clk);
      #2 {go, irq_clear, reg_rd, reg_wr, reg_addr, reg_wdata} = {op, a, w};
      @(posedge core_clk);
      #2 {go, irq_clear, reg_rd, reg_wr} = 4'h0;
      repeat (op[3] ? 4 : 0) @(posedge core_clk);
   endtask
   function automatic logic [15:0] adj(input logic [7:0] m);
      s = m[6:0] * (1 << front_end_gain) * (8 >> emitter_drive_strength) * (emitter_pulse_count + 1);
      s = m[7] ? val + s : val - s;
      return s < 0 ? 16'h0000 : s > 65535 ? 16'hffff : 16'(s);
   endfunction
   task automatic report_and_stop(input int late);
      n_errors += late;
      $display("mismatches %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      {core_clk, nrst, go, irq_clear, reg_rd, reg_wr, sensing_enable, persist_hit, raw_saturated} = '0;
      {reg_addr, reg_wdata, emitter_pulse_count, front_end_gain, emitter_drive_strength, val} = '0;
      void'($urandom(32'h7d367eb4));
      repeat (20) @(posedge core_clk);
      #2 nrst = 1'b1;
      acc(4'h1, 8'h13, 8'hff);
      for (int i = 0; i < 5; i++) begin
         acc(4'h2, 8'(40'h1e14191813 >> 8 * i), 8'h00);
         chk(reg_rdata_r, 16'h0000);
      end
      for (int i = 0; i < 40; i++) begin
         {front_end_gain, emitter_drive_strength, emitter_pulse_count[1:0], t, val, raw_saturated, persist_hit,
            sensing_enable} = 33'({$urandom, $urandom});
         acc(4'h1, 8'h1e, t);
         acc(4'h2, 8'h1e, 8'h00);
         chk(reg_rdata_r, t);
         e = adj(t);
         acc(4'h8, 8'h00, 8'h00);
         acc(4'h2, 8'h18, 8'h00);
         chk(reg_rdata_r, e[7:0]);
         val = ~val;
         acc(4'h8, 8'h00, 8'h00);
         acc(4'h2, 8'h19, 8'h00);
         chk(reg_rdata_r, e[15:8]);
         acc(4'h2, 8'h13, 8'h00);
         if (sensing_enable) chk(reg_rdata_r, {1'b0, raw_saturated, persist_hit, 5'h02});
         else chk(reg_rdata_r, {1'b0, raw_saturated, 6'h00});
         chk(int_out_oe_r, sensing_enable & persist_hit);
         acc(4'h4, 8'h00, 8'h00);
         chk(int_out_oe_r, 1'b0);
      end
      // leave a nonzero trim and a raised interrupt, then reset mid-run must clear both
      {sensing_enable, persist_hit} = 2'b11;
      acc(4'h1, 8'h1e, 8'h5a);
      acc(4'h8, 8'h00, 8'h00);
      acc(4'h2, 8'h13, 8'h00);
      chk(int_out_oe_r, 1'b1);
      nrst = 1'b0;
      repeat (2) @(posedge core_clk);
      #2 nrst = 1'b1;
      chk(int_out_oe_r, 1'b0);
      acc(4'h2, 8'h1e, 8'h00);
      chk(reg_rdata_r, 16'h0000);
      acc(4'h2, 8'h13, 8'h00);
      chk(reg_rdata_r, 16'h0000);
      report_and_stop(0);
   end
endmodule
`default_nettype wire
